// File: rtl/ssrg_defines.svh
// constants for the soft start ramp generator
`ifndef SSRG_DEFINES_SVH
`define SSRG_DEFINES_SVH
`define SSRG_CEIL_MIN_PCT 10'h0C8
`define SSRG_CEIL_MAX_PCT 10'h258
`define SSRG_FULL_VOLT 16'hFFFF
`define SSRG_TICK_NS 1000000
`define SSRG_CLK_NS 100
`define SSRG_TICK_CYC (`SSRG_TICK_NS / `SSRG_CLK_NS)
`define SSRG_PROF_VV 3'h1
`define SSRG_PROF_CC 3'h2
`define SSRG_PROF_VC 3'h3
`define SSRG_PROF_CV 3'h4
`define SSRG_KP_SHIFT 2
`endif

// File: rtl/ssrg_pkg.sv
// types for the soft start ramp generator
package ssrg_pkg;
    typedef enum logic [3:0] {
        SSRG_IDLE = 4'b0001,
        SSRG_RAMP = 4'b0010,
        SSRG_LIMIT = 4'b0100,
        SSRG_DONE = 4'b1000
    } ssrg_state_t;
endpackage

// File: rtl/ssrg_ramp_gen.sv
// soft start ramp generator: voltage or current set-point during acceleration
`timescale 1ns/1ps
`include "ssrg_defines.svh"

module ssrg_ramp_gen #(
    parameter int TICK_CYC = `SSRG_TICK_CYC,
    parameter int TIME_W = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start_cmd,
    input wire logic ramp2_select_pin,
    input wire logic at_speed_pin,
    input wire logic overload_trip,
    input wire logic [2:0] ramp_profile_select,
    input wire logic [15:0] ramp1_initial_voltage,
    input wire logic [15:0] ramp1_initial_current,
    input wire logic [TIME_W-1:0] ramp1_accel_time,
    input wire logic [9:0] ramp1_current_ceiling,
    input wire logic [15:0] ramp2_initial_voltage,
    input wire logic [15:0] ramp2_initial_current,
    input wire logic [TIME_W-1:0] ramp2_accel_time,
    input wire logic [9:0] ramp2_current_ceiling,
    input wire logic [15:0] motor_current,
    output logic [15:0] voltage_out,
    output logic [15:0] current_setpoint,
    output logic current_mode,
    output logic current_limit_active,
    output logic ramp_active,
    output logic ramp_done
);
    // refuse sizes the tick counter and 16-bit step math cannot serve
    if (TICK_CYC < 1 || TIME_W < 1 || TIME_W > 16) begin : g_bad_params
        $error("ssrg_ramp_gen: unsupported parameters");
    end

    // current in percent of rated, 16 bits; ceilings in percent
    function automatic logic [9:0] clamp_ceil(input logic [9:0] c);
        if (c < `SSRG_CEIL_MIN_PCT) begin
            return `SSRG_CEIL_MIN_PCT;
        end else if (c > `SSRG_CEIL_MAX_PCT) begin
            return `SSRG_CEIL_MAX_PCT;
        end
        return c;
    endfunction

    function automatic logic [15:0] step_of(input logic [15:0] lo, input logic [15:0] hi,
                                            input logic [TIME_W-1:0] t);
        logic [15:0] span;
        logic [16:0] num;
        span = (hi > lo) ? hi - lo : 16'h0000;
        if (t == '0) begin
            return 16'hFFFF;
        end
        num = {1'b0, span} + 17'(t) - 17'h00001;
        return (span == 16'h0000) ? 16'h0001 : 16'(num / 17'(t));
    endfunction

    function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b,
                                            input logic [15:0] lim);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return (s >= {1'b0, lim}) ? lim : s[15:0];
    endfunction

    // pin synchronisers
    logic [1:0] sel_sync_r;
    logic [1:0] spd_sync_r;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sel_sync_r <= 2'h0;
            spd_sync_r <= 2'h0;
        end else begin
            sel_sync_r <= {sel_sync_r[0], ramp2_select_pin};
            spd_sync_r <= {spd_sync_r[0], at_speed_pin};
        end
    end
    logic use_ramp2;
    logic at_speed;
    assign use_ramp2 = sel_sync_r[1];
    assign at_speed = spd_sync_r[1];

    // active set and ramp type
    logic cur_type;
    logic [15:0] init_lvl;
    logic [TIME_W-1:0] acc_time;
    logic [9:0] ceil_pct;
    logic [15:0] ceil_cur;
    always_comb begin
        case (ramp_profile_select)
            `SSRG_PROF_CC: cur_type = 1'b1;
            `SSRG_PROF_VC: cur_type = use_ramp2;
            `SSRG_PROF_CV: cur_type = !use_ramp2;
            default: cur_type = 1'b0;
        endcase
        if (use_ramp2) begin
            init_lvl = cur_type ? ramp2_initial_current : ramp2_initial_voltage;
            acc_time = ramp2_accel_time;
            ceil_pct = clamp_ceil(ramp2_current_ceiling);
        end else begin
            init_lvl = cur_type ? ramp1_initial_current : ramp1_initial_voltage;
            acc_time = ramp1_accel_time;
            ceil_pct = clamp_ceil(ramp1_current_ceiling);
        end
        ceil_cur = {6'h00, ceil_pct};
    end
    logic no_limit;
    assign no_limit = (ceil_pct == `SSRG_CEIL_MAX_PCT);

    // control tick
    logic [31:0] tick_cnt_r;
    logic tick;
    assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_r <= 32'h0;
        end else if (tick || !ramp_active) begin
            tick_cnt_r <= 32'h0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    ssrg_pkg::ssrg_state_t state_r;
    logic over_ceil;
    // live compare: a noisy current reading can toggle limiting
    assign over_ceil = !no_limit && (motor_current >= ceil_cur);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ssrg_pkg::SSRG_IDLE;
        end else if (!start_cmd || overload_trip) begin
            state_r <= ssrg_pkg::SSRG_IDLE;
        end else begin
            case (state_r)
                ssrg_pkg::SSRG_IDLE: state_r <= ssrg_pkg::SSRG_RAMP;
                ssrg_pkg::SSRG_RAMP, ssrg_pkg::SSRG_LIMIT: begin
                    if (at_speed) begin
                        state_r <= ssrg_pkg::SSRG_DONE;
                    end else if (over_ceil) begin
                        state_r <= ssrg_pkg::SSRG_LIMIT;
                    end else begin
                        state_r <= ssrg_pkg::SSRG_RAMP;
                    end
                end
                ssrg_pkg::SSRG_DONE: state_r <= ssrg_pkg::SSRG_DONE;
                default: state_r <= ssrg_pkg::SSRG_IDLE;
            endcase
        end
    end

    assign ramp_active = (state_r == ssrg_pkg::SSRG_RAMP) || (state_r == ssrg_pkg::SSRG_LIMIT);
    assign ramp_done = (state_r == ssrg_pkg::SSRG_DONE);
    assign current_limit_active = (state_r == ssrg_pkg::SSRG_LIMIT);

    // step computed once per start, at launch
    // rounded up so the ramp never outlasts the accel time
    logic [15:0] step_r;
    logic [15:0] target;
    assign target = cur_type ? ceil_cur : `SSRG_FULL_VOLT;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            step_r <= 16'h0000;
        end else if (state_r == ssrg_pkg::SSRG_IDLE) begin
            step_r <= step_of(init_lvl, target, acc_time);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            current_mode <= 1'b0;
        end else if (state_r == ssrg_pkg::SSRG_IDLE) begin
            current_mode <= cur_type;
        end
    end

    // current reference ramp
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            current_setpoint <= 16'h0000;
        end else if (state_r == ssrg_pkg::SSRG_IDLE) begin
            current_setpoint <= cur_type ? init_lvl : ceil_cur;
        end else if (ramp_active && tick && current_mode) begin
            current_setpoint <= sat_add(current_setpoint, step_r, ceil_cur);
        end
    end

    // while limited a voltage ramp freezes the voltage; current then follows the load
    // output voltage: open ramp, limit hold, or proportional trim on current error
    logic [15:0] err_step;
    assign err_step = (current_setpoint > motor_current) ?
        16'((current_setpoint - motor_current) >> `SSRG_KP_SHIFT) :
        16'((motor_current - current_setpoint) >> `SSRG_KP_SHIFT);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            voltage_out <= 16'h0000;
        end else if (state_r == ssrg_pkg::SSRG_IDLE) begin
            voltage_out <= cur_type ? 16'h0000 : init_lvl;
        end else if (state_r == ssrg_pkg::SSRG_DONE) begin
            voltage_out <= `SSRG_FULL_VOLT;
        end else if (tick) begin
            if (current_mode) begin
                // closed loop: move voltage toward current reference
                if (motor_current < current_setpoint) begin
                    voltage_out <= sat_add(voltage_out, err_step, `SSRG_FULL_VOLT);
                end else if (voltage_out > err_step) begin
                    voltage_out <= voltage_out - err_step;
                end else begin
                    voltage_out <= 16'h0000;
                end
            end else if (state_r == ssrg_pkg::SSRG_RAMP) begin
                voltage_out <= sat_add(voltage_out, step_r, `SSRG_FULL_VOLT);
            end
        end
    end

    // assertions
    a_ceiling_floor: assert property (@(posedge clk) disable iff (!resetn)
        ceil_pct >= `SSRG_CEIL_MIN_PCT && ceil_pct <= `SSRG_CEIL_MAX_PCT)
        else $error("ceiling outside 200..600");
    a_trip_ends: assert property (@(posedge clk) disable iff (!resetn)
        overload_trip |=> state_r == ssrg_pkg::SSRG_IDLE)
        else $error("overload did not end start");
    a_speed_ends: assert property (@(posedge clk) disable iff (!resetn)
        ramp_active && at_speed && start_cmd && !overload_trip |=> ramp_done)
        else $error("at speed did not end ramp");
    a_done_full: assert property (@(posedge clk) disable iff (!resetn)
        ramp_done ##1 ramp_done |-> voltage_out == `SSRG_FULL_VOLT)
        else $error("done without full voltage");
    a_cur_capped: assert property (@(posedge clk) disable iff (!resetn)
        ramp_active && current_mode |-> current_setpoint <= ceil_cur)
        else $error("current reference above ceiling");
    a_limit_hold: assert property (@(posedge clk) disable iff (!resetn)
        current_limit_active && !current_mode && tick |=> voltage_out == $past(voltage_out))
        else $error("voltage rose while limited");
    a_vramp_rise: assert property (@(posedge clk) disable iff (!resetn)
        state_r == ssrg_pkg::SSRG_RAMP && !current_mode && tick
        && voltage_out < `SSRG_FULL_VOLT |=> voltage_out > $past(voltage_out))
        else $error("voltage ramp stalled");
    a_no_limit: assert property (@(posedge clk) disable iff (!resetn)
        no_limit && ramp_active |=> !current_limit_active || !start_cmd)
        else $error("limiting at maximum ceiling");
    a_profile_cc: assert property (@(posedge clk) disable iff (!resetn)
        ramp_profile_select == `SSRG_PROF_CC |-> cur_type)
        else $error("profile 2 not current");
    a_launch_init: assert property (@(posedge clk) disable iff (!resetn)
        state_r == ssrg_pkg::SSRG_IDLE && start_cmd && !overload_trip && cur_type
        |=> current_setpoint == $past(init_lvl))
        else $error("current ramp start wrong");

    // a start in progress that neither stop, trip nor speed is ending
    sequence s_running;
        ramp_active && start_cmd && !overload_trip && !at_speed;
    endsequence
    sequence s_launch;
        state_r == ssrg_pkg::SSRG_IDLE && start_cmd && !overload_trip;
    endsequence
    a_limit_enter: assert property (@(posedge clk) disable iff (!resetn)
        s_running ##0 over_ceil |=> current_limit_active)
        else $error("ceiling reached without limiting");
    a_limit_stays: assert property (@(posedge clk) disable iff (!resetn)
        s_running ##0 (current_limit_active && over_ceil) |=> current_limit_active)
        else $error("limiting dropped above ceiling");
    a_limit_leave: assert property (@(posedge clk) disable iff (!resetn)
        s_running ##0 (current_limit_active && !over_ceil)
        |=> ramp_active && !current_limit_active)
        else $error("limiting held below ceiling");
    a_tick_only: assert property (@(posedge clk) disable iff (!resetn)
        s_running ##0 !tick |=> $stable(current_setpoint))
        else $error("set-point moved between ticks");
    a_step_jump: assert property (@(posedge clk) disable iff (!resetn)
        s_running ##0 (current_mode && tick && step_r == 16'hFFFF)
        |=> current_setpoint == $past(ceil_cur))
        else $error("current step missed ceiling");
    a_launch_volt: assert property (@(posedge clk) disable iff (!resetn)
        s_launch ##0 !cur_type |=> voltage_out == $past(init_lvl))
        else $error("voltage ramp start wrong");
    a_profile_vc: assert property (@(posedge clk) disable iff (!resetn)
        ramp_profile_select == `SSRG_PROF_VC |-> cur_type == use_ramp2)
        else $error("profile 3 type wrong");
    a_profile_cv: assert property (@(posedge clk) disable iff (!resetn)
        ramp_profile_select == `SSRG_PROF_CV |-> cur_type == !use_ramp2)
        else $error("profile 4 type wrong");
    a_mode_steady: assert property (@(posedge clk) disable iff (!resetn)
        s_running |=> $stable(current_mode))
        else $error("ramp type changed mid-start");
    a_done_holds: assert property (@(posedge clk) disable iff (!resetn)
        ramp_done && start_cmd && !overload_trip |=> ramp_done)
        else $error("done dropped during start");
endmodule

// File: tb/ssrg_motor_model.sv
// behavioural motor: current from applied voltage and load, at-speed detector
`timescale 1ns/1ps
module ssrg_motor_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] voltage_out,
    input wire logic [15:0] load_pct,
    input wire logic spin_up,
    output logic [15:0] motor_current,
    output logic at_speed_pin
);
    // no voltage means no current; an idle starter on a voltage ramp holds its initial voltage and still sees the load
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            motor_current <= 16'h0000;
            at_speed_pin <= 1'b0;
        end else begin
            motor_current <= (voltage_out == 16'h0000) ? 16'h0000 :
                load_pct + 16'(voltage_out[15:12]);
            at_speed_pin <= spin_up;
        end
    end
endmodule

// File: tb/testbench.sv
// self-checking bench for the soft start ramp generator
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic start_cmd = 1'b0, sel = 1'b0, overload_trip = 1'b0, spin_up = 1'b0;
    logic [2:0] prof = 3'h1;
    logic [15:0] iv1 = 16'h1000, iv2 = 16'h3000, ic1 = 16'h0064, ic2 = 16'h00C8;
    logic [15:0] at1 = 16'h0040, at2 = 16'h0040, load = 16'h0000, v0;
    logic [9:0] cl1 = 10'h258, cl2 = 10'h258;
    logic [15:0] motor_current, voltage_out, current_setpoint;
    logic at_speed_pin, current_mode, current_limit_active, ramp_active, ramp_done;
    int n_fail = 0, n_tests = 0, cyc = 0, k;
    int seed = 32'h022a;
    always #50 clk = ~clk;
    // short tick keeps a full 64-tick ramp near 256 cycles
    ssrg_ramp_gen #(.TICK_CYC(4), .TIME_W(16)) DUT (.clk(clk), .resetn(resetn),
        .start_cmd(start_cmd), .ramp2_select_pin(sel), .at_speed_pin(at_speed_pin),
        .overload_trip(overload_trip), .ramp_profile_select(prof),
        .ramp1_initial_voltage(iv1), .ramp1_initial_current(ic1),
        .ramp1_accel_time(at1), .ramp1_current_ceiling(cl1),
        .ramp2_initial_voltage(iv2), .ramp2_initial_current(ic2),
        .ramp2_accel_time(at2), .ramp2_current_ceiling(cl2),
        .motor_current(motor_current), .voltage_out(voltage_out),
        .current_setpoint(current_setpoint), .current_mode(current_mode),
        .current_limit_active(current_limit_active), .ramp_active(ramp_active),
        .ramp_done(ramp_done));
    ssrg_motor_model motor (.clk(clk), .resetn(resetn), .voltage_out(voltage_out),
        .load_pct(load), .spin_up(spin_up), .motor_current(motor_current),
        .at_speed_pin(at_speed_pin));
    function automatic logic cur_exp(int p, int s);
        if (p == 2) return 1'b1;
        if (p == 3) return s == 1;
        if (p == 4) return s == 0;
        return 1'b0;
    endfunction
    function automatic logic [15:0] init_exp(int p, int s);
        if (cur_exp(p, s)) return s ? ic2 : ic1;
        return s ? iv2 : iv1;
    endfunction
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    // pins pass a 2-flop sync, so settle them before the start edge
    task automatic go(int p, int s);
        prof <= 3'(p);
        sel <= 1'(s);
        tick(4);
        start_cmd <= 1'b1;
        k = 0;
        do begin
            tick(1);
            k++;
        end while (ramp_active !== 1'b1 && k < 8);
        check("ramp_active", 16'(ramp_active), 16'h0001);
    endtask
    task automatic stop_ramp();
        start_cmd <= 1'b0;
        tick(3);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        tick(10);
        check("rst_v", voltage_out, 16'h0000);
        check("rst_flags", 16'({current_mode, current_limit_active, ramp_active, ramp_done}),
            16'h0000);
        resetn <= 1'b1;
        tick(2);
        // profile 5 is out of range and must act as 1
        for (int p = 1; p <= 5; p++) begin
            for (int s = 0; s < 2; s++) begin
                iv2 <= 16'($random(seed)) & 16'h7FFF;
                ic1 <= 16'($random(seed)) & 16'h007F;
                go(p, s);
                check("mode", 16'(current_mode), 16'(cur_exp(p, s)));
                v0 = cur_exp(p, s) ? current_setpoint : voltage_out;
                check("init", v0, init_exp(p, s));
                stop_ramp();
            end
        end
        iv1 <= (16'($random(seed)) & 16'h7FFF) | 16'h0100;
        go(1, 0);
        v0 = voltage_out;
        tick(12);
        check("rise", 16'(voltage_out > v0), 16'h0001);
        check("early_done", 16'(ramp_done), 16'h0000);
        spin_up <= 1'b1;
        k = 0;
        while (ramp_done !== 1'b1 && k < 8) begin
            tick(1);
            k++;
        end
        check("done", 16'(ramp_done), 16'h0001);
        tick(1);
        check("cut_short", voltage_out, 16'hFFFF);
        check("lim_off", 16'(current_limit_active), 16'h0000);
        spin_up <= 1'b0;
        stop_ramp();
        cl1 <= 10'h12C;
        load <= 16'h0140 + (16'($random(seed)) & 16'h003F);
        go(1, 0);
        tick(8);
        check("lim_on", 16'(current_limit_active), 16'h0001);
        v0 = voltage_out;
        tick(40);
        check("lim_hold", voltage_out, v0);
        check("lim_long", 16'(current_limit_active), 16'h0001);
        load <= 16'h0064;
        tick(12);
        check("lim_rise", 16'(voltage_out > v0), 16'h0001);
        overload_trip <= 1'b1;
        tick(3);
        check("trip", 16'({ramp_active, current_limit_active}), 16'h0000);
        overload_trip <= 1'b0;
        stop_ramp();
        cl1 <= 10'h0FA;
        load <= 16'h0000;
        go(2, 0);
        // 64 ticks of 4 cycles: the ceiling must be reached by then
        tick(256);
        check("cur_reach", current_setpoint, 16'h00FA);
        check("cur_up", 16'(current_setpoint > ic1), 16'h0001);
        tick(44);
        check("cur_cap", current_setpoint, 16'h00FA);
        stop_ramp();
        at1 <= 16'h0000;
        go(2, 0);
        tick(4);
        check("cur_step", current_setpoint, 16'h00FA);
        stop_ramp();
        go(1, 0);
        tick(4);
        check("volt_step", voltage_out, 16'hFFFF);
        stop_ramp();
        at1 <= 16'h0040;
        cl1 <= 10'h064;
        load <= 16'h0096;
        go(1, 0);
        tick(20);
        check("clamp", 16'(current_limit_active), 16'h0000);
        stop_ramp();
        test_done();
    end
endmodule
